// file: hw/bts_pkg.sv
// Purpose: Shared constants and types for the burst-of-two SRAM port
// Assumes: 20 MHz system clock on both ends
// Notes:   Link clock K is made by the controller end from its own clock
package bts_pkg;
  // ==========================================================
  // Widths
  localparam int BTS_AW         = 20;
  localparam int BTS_BEAT_W     = 18;
  localparam int BTS_LANES      = 2;
  localparam int BTS_LANE_W     = 9;
  localparam int BTS_WORD_W     = 36;
  localparam int BTS_FIFO_DEPTH = 16;
  // ==========================================================
  // Timing
  localparam int BTS_CLK_MHZ        = 20;
  localparam int BTS_K_PERIOD_NS    = 400;
  localparam int BTS_K_HALF_CYC     =
    BTS_K_PERIOD_NS * BTS_CLK_MHZ / 2000;
  localparam int BTS_LEGACY_MAX_MHZ = 167;
  localparam int BTS_SYNC_STAGES    = 3;
  localparam int BTS_NOP_RD_WR      = 2;
  // ==========================================================
  // Read pipeline, counted in half K cycles from the load edge
  localparam int         BTS_RD_PIPE      = 7;
  localparam logic [2:0] BTS_FIRST_NORMAL = 3'h5;
  localparam logic [2:0] BTS_FIRST_LEGACY = 3'h2;
  // ==========================================================
  // Controller write data phase
  typedef enum logic [1:0] {
    BTS_WPH_IDLE = 2'b00,
    BTS_WPH_LO   = 2'b01,
    BTS_WPH_HI   = 2'b10
  } bts_wph_e;
endpackage

// file: hw/bts_if.sv
// Purpose: Pins between the SRAM port and its memory controller
// Assumes: Data bus resolved here from the device output enable alone
// Notes:   Controller value shows when the device does not drive
`timescale 1ns/1ps
`default_nettype none
interface bts_if #(parameter int AW = bts_pkg::BTS_AW);
  logic          k;
  logic          load_strobe_n;
  logic          rw;
  logic [AW-1:0] addr;
  logic [1:0]    byte_lane_select_n;
  logic          pll_disable_n;
  logic [17:0]   ctl_dq_o;
  logic          ctl_dq_oe_n;
  logic [17:0]   dev_dq_o;
  logic          dev_dq_oe_n;
  logic [17:0]   dq;
  logic          echo_clock;
  logic          echo_clock_n;
  logic          output_valid_flag;

  assign dq = !dev_dq_oe_n ? dev_dq_o : ctl_dq_o;

  modport ctl (
    output k, load_strobe_n, rw, addr, byte_lane_select_n,
    output pll_disable_n, ctl_dq_o, ctl_dq_oe_n,
    input  dq, echo_clock, echo_clock_n, output_valid_flag
  );
  modport dev (
    input  k, load_strobe_n, rw, addr, byte_lane_select_n,
    input  pll_disable_n, dq,
    output dev_dq_o, dev_dq_oe_n, echo_clock, echo_clock_n,
    output output_valid_flag
  );
endinterface
`default_nettype wire

// file: hw/bts_fifo.sv
// Purpose: Request buffer between user port and link issue logic
// Assumes: Single clock, one push and one pop per cycle at most
// Notes:   Ready drops honestly when full
`timescale 1ns/1ps
`default_nettype none
module bts_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = bts_pkg::BTS_FIFO_DEPTH
) (
  input  wire logic         i_clock,
  input  wire logic         i_rst_n,
  input  wire logic         i_in_valid,
  output logic              o_in_ready,
  input  wire logic [W-1:0] i_in_data,
  output logic              o_out_valid,
  input  wire logic         i_out_ready,
  output logic      [W-1:0] o_out_data
);
  import bts_pkg::*;
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [W-1:0]  mem_ff [DEPTH];
  logic [PW-1:0] wp_ff, nxt_wp, rp_ff, nxt_rp;
  logic [CW-1:0] cnt_ff, nxt_cnt;
  logic          push, pop;

  assign o_in_ready  = (cnt_ff != CW'(DEPTH));
  assign o_out_valid = (cnt_ff != '0);
  assign o_out_data  = mem_ff[rp_ff];
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;

  always_comb begin
    nxt_wp  = push ? PW'(wp_ff + 1'b1) : wp_ff;
    nxt_rp  = pop ? PW'(rp_ff + 1'b1) : rp_ff;
    nxt_cnt = cnt_ff;
    if (push && !pop) begin
      nxt_cnt = CW'(cnt_ff + 1'b1);
    end else if (pop && !push) begin
      nxt_cnt = CW'(cnt_ff - 1'b1);
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wp_ff  <= '0;
      rp_ff  <= '0;
      cnt_ff <= '0;
    end else begin
      wp_ff  <= nxt_wp;
      rp_ff  <= nxt_rp;
      cnt_ff <= nxt_cnt;
    end
  end

  // Storage has no reset; empty flag guards stale words
  always_ff @(posedge i_clock) begin
    if (push) begin
      mem_ff[wp_ff] <= i_in_data;
    end
  end
endmodule
`default_nettype wire

// file: hw/bts_dev.sv
// Purpose: Device end of the burst-of-two DDR SRAM port
// Assumes: K and PLL disable sampled by i_clock through three flops, other pins four
// Notes:   K rise and K fall stand in for K and K-bar rising edges
// ==========================================================
// Notes on behaviour
// R1: Free-running echo clock pair follows K
// R2: PLL disable low selects legacy timing mode
// R3: Read latency 2.5 cycles, legacy one cycle
// R4: Accesses start only on K rising edge
// R5: Data captured and launched on both edges
// R6: Control inputs registered on K rise
// R7: Burst of two sequential 18-bit words
// R8: Read load stores address in read register
// R9: First read word on K-bar, second K; legacy K, then K-bar
// R10: Back-to-back reads pipelined, each completes
// R11: Finish reads, then release data bus
// R12: Write load stores address in write register
// R13: Write words latched on next K, K-bar
// R14: 36 bits written; write every K cycle
// R15: Deselected writes finish, inputs then ignored
// R16: Deselected byte lane leaves memory unchanged
// R17: Controller inserts two NOPs read to write
// R18: Read after write returns newest data
// R19: Valid flag rises half cycle before data
// R20: Load strobe high starts no access
`timescale 1ns/1ps
`default_nettype none
module bts_dev #(
  parameter int AW = bts_pkg::BTS_AW
) (
  input  wire logic i_clock,
  input  wire logic i_rst_n,
  bts_if.dev        lnk,
  output logic      o_legacy_mode
);
  import bts_pkg::*;
  localparam int IN_W = 2 + AW + BTS_LANES + BTS_BEAT_W;

  // ==========================================================
  // Pin synchronisers
  logic [2:0]      k_s_ff;
  logic            k_lvl_ff, nxt_k_lvl;
  logic [2:0]      pll_s_ff;
  logic            pll_lvl_ff, nxt_pll_lvl;
  logic [IN_W-1:0] in_s1_ff, in_s2_ff, in_s3_ff, in_s4_ff;
  logic            kr, kf, he;
  logic            p_ld_n, p_rw;
  logic [AW-1:0]   p_addr;
  logic [1:0]      p_bsel_n;
  logic [17:0]     p_din;

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      k_s_ff   <= '0;
      pll_s_ff <= 3'h7;
      in_s1_ff <= '0;
      in_s2_ff <= '0;
      in_s3_ff <= '0;
      in_s4_ff <= '0;
    end else begin
      k_s_ff   <= {k_s_ff[1:0], lnk.k};
      pll_s_ff <= {pll_s_ff[1:0], lnk.pll_disable_n};
      in_s1_ff <= {lnk.load_strobe_n, lnk.rw, lnk.addr,
                   lnk.byte_lane_select_n, lnk.dq};
      in_s2_ff <= in_s1_ff;
      in_s3_ff <= in_s2_ff;
      in_s4_ff <= in_s3_ff;
    end
  end

  // Edge counts once stages two and three agree
  always_comb begin
    nxt_k_lvl   = k_lvl_ff;
    nxt_pll_lvl = pll_lvl_ff;
    if (k_s_ff[1] == k_s_ff[2]) begin
      nxt_k_lvl = k_s_ff[2];
    end
    if (pll_s_ff[1] == pll_s_ff[2]) begin
      nxt_pll_lvl = pll_s_ff[2];
    end
  end

  assign kr = nxt_k_lvl && !k_lvl_ff; // R4
  assign kf = !nxt_k_lvl && k_lvl_ff; // R5
  assign he = kr || kf;
  // Pins as they stood just before the K edge; the far end
  // moves its beats on that edge itself
  assign {p_ld_n, p_rw, p_addr, p_bsel_n, p_din} = in_s4_ff;

  // ==========================================================
  // Array, two banks of 18 held as one 36-bit word per address
  logic [BTS_WORD_W-1:0] mem [2**AW];
  logic [BTS_WORD_W-1:0] merged;
  logic                  commit;

  // ==========================================================
  // Access state
  logic          wload_ff, nxt_wload;
  logic [AW-1:0] wa0_ff, nxt_wa0;
  logic          wdata_ff, nxt_wdata;
  logic [AW-1:0] wa1_ff, nxt_wa1;
  logic [17:0]   wlo_ff, nxt_wlo;
  logic [1:0]    wlo_n_ff, nxt_wlo_n;
  logic [BTS_RD_PIPE-1:0] rv_ff, nxt_rv;
  logic [AW-1:0] ra_ff [BTS_RD_PIPE];
  logic [AW-1:0] nxt_ra [BTS_RD_PIPE];
  logic [2:0]    first;
  logic [17:0]   q_ff, nxt_q;
  logic          oe_n_ff, nxt_oe_n;
  logic          output_valid_flag_ff, nxt_output_valid_flag;
  logic          echo_ff, echo_n_ff;

  always_comb begin
    nxt_wload = wload_ff;
    nxt_wa0   = wa0_ff;
    nxt_wdata = wdata_ff;
    nxt_wa1   = wa1_ff;
    nxt_wlo   = wlo_ff;
    nxt_wlo_n = wlo_n_ff;
    nxt_rv    = rv_ff;
    nxt_ra    = ra_ff;
    nxt_q     = q_ff;
    nxt_oe_n  = oe_n_ff;
    nxt_output_valid_flag  = output_valid_flag_ff;
    commit    = 1'b0;
    merged    = mem[wa1_ff];
    // R2: legacy mode is only sensible up to BTS_LEGACY_MAX_MHZ
    first = pll_lvl_ff ? BTS_FIRST_NORMAL : BTS_FIRST_LEGACY; // R3
    if (kr) begin
      // R13: first word of the burst loaded last K rise
      nxt_wdata = wload_ff;
      nxt_wa1   = wa0_ff;
      nxt_wlo   = p_din;
      nxt_wlo_n = p_bsel_n;
      // R6: control sampled only here; R20: strobe high adds nothing
      nxt_wload = !p_ld_n && !p_rw; // R12
      if (!p_ld_n) begin
        nxt_wa0 = p_addr; // R12
      end
    end
    if (kf && wdata_ff) begin
      // R15: data pins read only while a write burst is open
      commit    = 1'b1; // R14
      nxt_wdata = 1'b0;
      for (int l = 0; l < BTS_LANES; l++) begin
        if (!wlo_n_ff[l]) begin
          merged[l*BTS_LANE_W +: BTS_LANE_W] =
            wlo_ff[l*BTS_LANE_W +: BTS_LANE_W]; // R16
        end
        if (!p_bsel_n[l]) begin
          merged[BTS_BEAT_W + l*BTS_LANE_W +: BTS_LANE_W] =
            p_din[l*BTS_LANE_W +: BTS_LANE_W]; // R16
        end
      end
    end
    if (he) begin
      // Shift read slots one half cycle; new read enters at K rise
      nxt_rv = {rv_ff[BTS_RD_PIPE-2:0], kr && !p_ld_n && p_rw}; // R10
      for (int i = BTS_RD_PIPE - 1; i > 0; i--) begin
        nxt_ra[i] = ra_ff[i-1];
      end
      nxt_ra[0] = p_addr; // R8
      // Fetch at launch time so a write committed earlier is seen
      if (nxt_rv[first]) begin
        nxt_q    = mem[nxt_ra[first]][BTS_BEAT_W-1:0]; // R9
        nxt_oe_n = 1'b0;
      end else if (nxt_rv[first + 3'h1]) begin
        nxt_q    = mem[nxt_ra[first + 3'h1]][BTS_WORD_W-1:BTS_BEAT_W]; // R7
        nxt_oe_n = 1'b0;
      end else begin
        nxt_oe_n = 1'b1; // R11
      end
      nxt_output_valid_flag = nxt_rv[first - 3'h1] || nxt_rv[first]; // R19
    end
  end

  // R18: commit lands before any later read reaches its fetch slot
  always_ff @(posedge i_clock) begin
    if (commit) begin
      mem[wa1_ff] <= merged; // R14
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      k_lvl_ff   <= 1'b0;
      pll_lvl_ff <= 1'b1;
      wload_ff   <= 1'b0;
      wa0_ff     <= '0;
      wdata_ff   <= 1'b0;
      wa1_ff     <= '0;
      wlo_ff     <= '0;
      wlo_n_ff   <= 2'h3;
      rv_ff      <= '0;
      for (int i = 0; i < BTS_RD_PIPE; i++) begin
        ra_ff[i] <= '0;
      end
      q_ff       <= '0;
      oe_n_ff    <= 1'b1;
      output_valid_flag_ff    <= 1'b0;
      echo_ff    <= 1'b0;
      echo_n_ff  <= 1'b1;
    end else begin
      k_lvl_ff   <= nxt_k_lvl;
      pll_lvl_ff <= nxt_pll_lvl;
      wload_ff   <= nxt_wload;
      wa0_ff     <= nxt_wa0;
      wdata_ff   <= nxt_wdata;
      wa1_ff     <= nxt_wa1;
      wlo_ff     <= nxt_wlo;
      wlo_n_ff   <= nxt_wlo_n;
      rv_ff      <= nxt_rv;
      ra_ff      <= nxt_ra;
      q_ff       <= nxt_q;
      oe_n_ff    <= nxt_oe_n;
      output_valid_flag_ff    <= nxt_output_valid_flag;
      echo_ff    <= nxt_k_lvl; // R1
      echo_n_ff  <= !nxt_k_lvl; // R1
    end
  end

  // ==========================================================
  // Outputs
  assign lnk.dev_dq_o          = q_ff;
  assign lnk.dev_dq_oe_n       = oe_n_ff;
  assign lnk.output_valid_flag = output_valid_flag_ff;
  assign lnk.echo_clock        = echo_ff;
  assign lnk.echo_clock_n      = echo_n_ff;
  assign o_legacy_mode         = !pll_lvl_ff; // R2
endmodule
`default_nettype wire

// file: hw/bts_ctl.sv
// Purpose: Controller end: buffers requests, drives K and bursts
// Assumes: Device echo and data pins sampled through three flops
// Notes:   Commands change on K fall so they are stable at K rise
`timescale 1ns/1ps
`default_nettype none
module bts_ctl #(
  parameter int AW     = bts_pkg::BTS_AW,
  parameter int DEPTH  = bts_pkg::BTS_FIFO_DEPTH,
  parameter int NOP_RW = bts_pkg::BTS_NOP_RD_WR
) (
  input  wire logic          i_clock,
  input  wire logic          i_rst_n,
  input  wire logic          i_req_valid,
  output logic               o_req_ready,
  input  wire logic          i_req_write,
  input  wire logic [AW-1:0] i_req_addr,
  input  wire logic [35:0]   i_req_data,
  input  wire logic [3:0]    i_req_be_n,
  input  wire logic          i_pll_disable_n,
  output logic               o_rd_valid,
  output logic      [35:0]   o_rd_data,
  bts_if.ctl                 lnk
);
  import bts_pkg::*;
  localparam int CMD_W = 1 + AW + 36 + 4;

  // ==========================================================
  // K divider; controller owns the link clock
  logic [3:0] div_ff, nxt_div;
  logic       k_ff, nxt_k, kr, kf, tick;
  assign tick = (div_ff == 4'(BTS_K_HALF_CYC - 1));
  assign kr   = tick && !k_ff;
  assign kf   = tick && k_ff;

  // ==========================================================
  // Request buffer
  logic [CMD_W-1:0] head;
  logic             head_v, pop;
  logic             h_wr;
  logic [AW-1:0]    h_addr;
  logic [35:0]      h_data;
  logic [3:0]       h_be_n;
  bts_fifo #(.W(CMD_W), .DEPTH(DEPTH)) u_fifo (
    .i_clock     (i_clock),
    .i_rst_n     (i_rst_n),
    .i_in_valid  (i_req_valid),
    .o_in_ready  (o_req_ready),
    .i_in_data   ({i_req_write, i_req_addr, i_req_data, i_req_be_n}),
    .o_out_valid (head_v),
    .i_out_ready (pop),
    .o_out_data  (head)
  );
  assign {h_wr, h_addr, h_data, h_be_n} = head;

  // ==========================================================
  // Issue and write data
  logic          ld_n_ff, nxt_ld_n, rw_ff, nxt_rw;
  logic [AW-1:0] a_ff, nxt_a;
  logic [1:0]    nop_ff, nxt_nop;
  logic          wiss_ff, nxt_wiss;
  logic [35:0]   wd_ff, nxt_wd;
  logic [3:0]    wbe_ff, nxt_wbe;
  logic [17:0]   hi_ff, nxt_hi;
  logic [1:0]    hbe_ff, nxt_hbe;
  logic [17:0]   do_ff, nxt_do;
  logic [1:0]    bs_ff, nxt_bs;
  logic          oe_n_ff, nxt_oe_n;
  bts_wph_e      ph_ff, nxt_ph;
  logic          pll_ff;
  logic          gap_ok;

  // Third NOP covers the device's pin sampling lag at this K rate: raise NOP_RW
  assign gap_ok = !h_wr || (nop_ff >= 2'(NOP_RW)); // R17
  assign pop    = kf && head_v && gap_ok;

  always_comb begin
    nxt_div  = tick ? 4'h0 : 4'(div_ff + 4'h1);
    nxt_k    = tick ? !k_ff : k_ff;
    nxt_ld_n = ld_n_ff;
    nxt_rw   = rw_ff;
    nxt_a    = a_ff;
    nxt_nop  = nop_ff;
    nxt_wiss = wiss_ff;
    nxt_wd   = wd_ff;
    nxt_wbe  = wbe_ff;
    nxt_hi   = hi_ff;
    nxt_hbe  = hbe_ff;
    nxt_do   = do_ff;
    nxt_bs   = bs_ff;
    nxt_oe_n = oe_n_ff;
    nxt_ph   = ph_ff;
    if (kf) begin
      nxt_ld_n = !pop;
      nxt_wiss = pop && h_wr;
      if (pop) begin
        nxt_rw  = !h_wr;
        nxt_a   = h_addr;
        nxt_wd  = h_data;
        nxt_wbe = h_be_n;
        nxt_nop = h_wr ? nop_ff : 2'h0;
      end else if (nop_ff != 2'h3) begin
        nxt_nop = 2'(nop_ff + 2'h1);
      end
      case (wiss_ff)
        1'b1: begin
          nxt_do   = wd_ff[17:0];
          nxt_bs   = wbe_ff[1:0];
          nxt_hi   = wd_ff[35:18];
          nxt_hbe  = wbe_ff[3:2];
          nxt_oe_n = 1'b0;
          nxt_ph   = BTS_WPH_LO;
        end
        default: begin
          nxt_oe_n = 1'b1;
          nxt_bs   = 2'h3;
          nxt_ph   = BTS_WPH_IDLE;
        end
      endcase
    end else if (kr) begin
      case (ph_ff)
        BTS_WPH_LO: begin
          nxt_do = hi_ff;
          nxt_bs = hbe_ff;
          nxt_ph = BTS_WPH_HI;
        end
        BTS_WPH_HI:   nxt_ph = ph_ff;
        BTS_WPH_IDLE: nxt_ph = ph_ff;
        default:      nxt_ph = BTS_WPH_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      div_ff  <= 4'h0;
      k_ff    <= 1'b0;
      ld_n_ff <= 1'b1;
      rw_ff   <= 1'b1;
      a_ff    <= '0;
      nop_ff  <= 2'h3;
      wiss_ff <= 1'b0;
      wd_ff   <= '0;
      wbe_ff  <= 4'hF;
      hi_ff   <= '0;
      hbe_ff  <= 2'h3;
      do_ff   <= '0;
      bs_ff   <= 2'h3;
      oe_n_ff <= 1'b1;
      ph_ff   <= BTS_WPH_IDLE;
      pll_ff  <= 1'b1;
    end else begin
      div_ff  <= nxt_div;
      k_ff    <= nxt_k;
      ld_n_ff <= nxt_ld_n;
      rw_ff   <= nxt_rw;
      a_ff    <= nxt_a;
      nop_ff  <= nxt_nop;
      wiss_ff <= nxt_wiss;
      wd_ff   <= nxt_wd;
      wbe_ff  <= nxt_wbe;
      hi_ff   <= nxt_hi;
      hbe_ff  <= nxt_hbe;
      do_ff   <= nxt_do;
      bs_ff   <= nxt_bs;
      oe_n_ff <= nxt_oe_n;
      ph_ff   <= nxt_ph;
      pll_ff  <= i_pll_disable_n;
    end
  end

  // ==========================================================
  // Read capture on echo edges, paced by the valid flag
  logic [19:0] rs1_ff, rs2_ff, rs3_ff;
  logic        e_lvl_ff, qv_prev_ff, beat_ff, rdv_ff;
  logic [17:0] lo_ff;
  logic [35:0] rdd_ff;
  logic        e_edge;
  assign e_edge = (rs2_ff[19] == rs3_ff[19]) && (rs3_ff[19] != e_lvl_ff);

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rs1_ff     <= '0;
      rs2_ff     <= '0;
      rs3_ff     <= '0;
      e_lvl_ff   <= 1'b0;
      qv_prev_ff <= 1'b0;
      beat_ff    <= 1'b0;
      lo_ff      <= '0;
      rdd_ff     <= '0;
      rdv_ff     <= 1'b0;
    end else begin
      rs1_ff <= {lnk.echo_clock, lnk.output_valid_flag, lnk.dq};
      rs2_ff <= rs1_ff;
      rs3_ff <= rs2_ff;
      rdv_ff <= 1'b0;
      if (e_edge) begin
        e_lvl_ff   <= rs3_ff[19];
        qv_prev_ff <= rs3_ff[18];
        if (qv_prev_ff) begin
          beat_ff <= !beat_ff;
          if (!beat_ff) begin
            lo_ff <= rs3_ff[17:0];
          end else begin
            rdd_ff <= {rs3_ff[17:0], lo_ff};
            rdv_ff <= 1'b1;
          end
        end
      end
    end
  end

  assign o_rd_valid             = rdv_ff;
  assign o_rd_data              = rdd_ff;
  assign lnk.k                  = k_ff;
  assign lnk.load_strobe_n      = ld_n_ff;
  assign lnk.rw                 = rw_ff;
  assign lnk.addr               = a_ff;
  assign lnk.byte_lane_select_n = bs_ff;
  assign lnk.pll_disable_n      = pll_ff;
  assign lnk.ctl_dq_o           = do_ff;
  assign lnk.ctl_dq_oe_n        = oe_n_ff;
endmodule
`default_nettype wire

// file: test/bts_checker.sv
// Purpose: Assertions on the link between the two SRAM port ends
// Assumes: One i_clock domain; k is divided down from it
// Notes:   Windows allow for the three-flop sampling of k
`timescale 1ns/1ps
`default_nettype none
module bts_checker (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic k,
  input wire logic load_strobe_n,
  input wire logic rw,
  input wire logic ctl_dq_oe_n,
  input wire logic dev_dq_oe_n,
  input wire logic echo_clock,
  input wire logic echo_clock_n,
  input wire logic output_valid_flag
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  // ==========================================================
  // Clocks
  property p_echo_pair;
    echo_clock != echo_clock_n;
  endproperty
  a_echo_pair: assert property (p_echo_pair)
    else $error("echo pair not complementary");
  property p_echo_run;
    $rose(echo_clock) |-> ##[1:12] $fell(echo_clock);
  endproperty
  a_echo_run: assert property (p_echo_run)
    else $error("echo clock stopped");
  property p_k_half;
    $rose(k) |-> k[*4] ##1 !k;
  endproperty
  a_k_half: assert property (p_k_half)
    else $error("link clock half period wrong");
  // ==========================================================
  // Commands and data
  property p_cmd_hold;
    $rose(k) |-> ($stable(load_strobe_n) && $stable(rw))[*4];
  endproperty
  a_cmd_hold: assert property (p_cmd_hold)
    else $error("command moved while link clock high");
  property p_no_fight;
    !(!dev_dq_oe_n && !ctl_dq_oe_n);
  endproperty
  a_no_fight: assert property (p_no_fight)
    else $error("both ends drive data bus");
  property p_wr_data;
    $rose(k) && !load_strobe_n && !rw |-> ##[3:5] !ctl_dq_oe_n;
  endproperty
  a_wr_data: assert property (p_wr_data)
    else $error("write data not presented");
  property p_wr_beats;
    $fell(ctl_dq_oe_n) |-> (!ctl_dq_oe_n)[*8];
  endproperty
  a_wr_beats: assert property (p_wr_beats)
    else $error("write burst cut short");
  property p_rd_valid;
    $rose(k) && !load_strobe_n && rw |-> ##[6:30] output_valid_flag;
  endproperty
  a_rd_valid: assert property (p_rd_valid)
    else $error("read never flagged valid");
  property p_valid_lead;
    $rose(output_valid_flag) |-> dev_dq_oe_n ##[3:5] !dev_dq_oe_n;
  endproperty
  a_valid_lead: assert property (p_valid_lead)
    else $error("valid flag not half cycle ahead");
  property p_rd_beats;
    $fell(dev_dq_oe_n) |-> (!dev_dq_oe_n)[*7];
  endproperty
  a_rd_beats: assert property (p_rd_beats)
    else $error("read burst cut short");
  property p_release;
    $fell(output_valid_flag) |-> ##[1:12] dev_dq_oe_n;
  endproperty
  a_release: assert property (p_release)
    else $error("data bus not released");
endmodule
`default_nettype wire

// file: test/bts_bench.sv
// Purpose: Self-checking bench for both ends of the SRAM port
// Assumes: Ends joined by bts_if; AW shrunk to keep the array small
// Notes:   Expected data comes from a bench-side memory image
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
  fail_count++; $display("BAD %s exp %h got %h", nm, e, g); end end
module burst_two_sram_port_bench;
  import bts_pkg::*;
  localparam int AW = 8;
  logic          i_clock;
  logic          i_rst_n;
  logic          req_valid;
  logic          req_ready;
  logic          req_write;
  logic [AW-1:0] req_addr;
  logic [35:0]   req_data;
  logic [3:0]    req_be_n;
  logic          pll_n;
  logic          rd_valid;
  logic [35:0]   rd_data;
  logic          legacy;
  logic          k_q;
  logic [35:0]   exp_w;
  logic [35:0]   mem [int];
  logic [35:0]   exp_q [$];
  int            fail_count = 0;
  int            n_compared = 0;
  int            stall_cnt = 0;
  int            cyc = 0;
  int            load_cyc = 0;
  int            last_lat = 0;

  bts_if #(.AW(AW)) lnk_if ();
  // Third NOP covers the device's pin sampling lag on turnaround
  bts_ctl #(.AW(AW), .NOP_RW(3)) bts_ctl_inst (
    .i_clock         (i_clock),
    .i_rst_n         (i_rst_n),
    .i_req_valid     (req_valid),
    .o_req_ready     (req_ready),
    .i_req_write     (req_write),
    .i_req_addr      (req_addr),
    .i_req_data      (req_data),
    .i_req_be_n      (req_be_n),
    .i_pll_disable_n (pll_n),
    .o_rd_valid      (rd_valid),
    .o_rd_data       (rd_data),
    .lnk             (lnk_if)
  );
  bts_dev #(.AW(AW)) bts_dev_inst (
    .i_clock       (i_clock),
    .i_rst_n       (i_rst_n),
    .lnk           (lnk_if),
    .o_legacy_mode (legacy)
  );
  bts_checker bts_checker_inst (
    .i_clock           (i_clock),
    .i_rst_n           (i_rst_n),
    .k                 (lnk_if.k),
    .load_strobe_n     (lnk_if.load_strobe_n),
    .rw                (lnk_if.rw),
    .ctl_dq_oe_n       (lnk_if.ctl_dq_oe_n),
    .dev_dq_oe_n       (lnk_if.dev_dq_oe_n),
    .echo_clock        (lnk_if.echo_clock),
    .echo_clock_n      (lnk_if.echo_clock_n),
    .output_valid_flag (lnk_if.output_valid_flag)
  );
  // ==========================================================
  // Clock, read monitor, closing
  initial begin
    i_clock = 1'b0;
    forever #25 i_clock = ~i_clock;
  end
  // Latency counted from the load rise, so K phase drops out
  always @(posedge i_clock) begin
    cyc <= cyc + 1;
    k_q <= lnk_if.k;
    if (lnk_if.k === 1'b1 && k_q === 1'b0 && !lnk_if.load_strobe_n)
      load_cyc <= cyc;
    if (rd_valid === 1'b1) begin
      last_lat <= cyc - load_cyc;
      exp_w = (exp_q.size() != 0) ? exp_q.pop_front() : 36'h0;
      `CHK("read data", exp_w, rd_data)
    end
  end
  task automatic results();
    $display("Compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // ==========================================================
  // Request helpers
  task automatic send(input logic w, input logic [AW-1:0] a,
                      input logic [35:0] d, input logic [3:0] be);
    int n;
    @(negedge i_clock);
    req_valid = 1'b1;
    req_write = w;
    req_addr = a;
    req_data = d;
    req_be_n = be;
    n = 0;
    while (req_ready !== 1'b1 && n < 2000) begin
      @(negedge i_clock);
      n++;
    end
    stall_cnt += n;
    @(posedge i_clock);
  endtask
  task automatic wr(input logic [AW-1:0] a, input logic [35:0] d,
                    input logic [3:0] be);
    for (int i = 0; i < 4; i++)
      if (!be[i]) mem[a][9*i +: 9] = d[9*i +: 9];
    send(1'b1, a, d, be);
  endtask
  task automatic rd(input logic [AW-1:0] a);
    exp_q.push_back(mem[a]);
    send(1'b0, a, 36'h0, 4'hF);
  endtask
  task automatic drain();
    int n;
    @(negedge i_clock);
    req_valid = 1'b0;
    n = 0;
    while (exp_q.size() != 0 && n < 5000) begin
      @(negedge i_clock);
      n++;
    end
    `CHK("reads left", 0, exp_q.size())
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_basic();
    for (int i = 0; i < 6; i++)
      wr(AW'(i * 37), {18'(i), 18'h3FFFF - 18'(i)}, 4'h0);
    for (int i = 0; i < 6; i++)
      rd(AW'(i * 37));
    wr(AW'(85), 36'hA5A5A5A5A, 4'h0);
    rd(AW'(85));
    drain();
  endtask
  task automatic t_lanes();
    for (int b = 0; b < 16; b++) begin
      wr(AW'(16), {4{9'(b * 17 + 1)}}, 4'(b));
      rd(AW'(16));
    end
    drain();
  endtask
  // Fill the request buffer faster than the link can issue
  task automatic t_fifo();
    stall_cnt = 0;
    for (int i = 0; i < 24; i++)
      wr(AW'(128 + i), {36{1'b1}} ^ 36'(i * 4099), 4'h0);
    `CHK("buffer refused", 1'b1, stall_cnt > 0)
    for (int i = 0; i < 24; i++)
      rd(AW'(128 + i));
    drain();
    `CHK("buffer empty", 1'b1, req_ready)
  endtask
  task automatic t_idle();
    int   rises;
    logic e_q;
    rises = 0;
    e_q = lnk_if.echo_clock;
    for (int i = 0; i < 80; i++) begin
      @(negedge i_clock);
      `CHK("bus released", 1'b1, lnk_if.dev_dq_oe_n)
      if (lnk_if.echo_clock === 1'b1 && e_q === 1'b0)
        rises++;
      e_q = lnk_if.echo_clock;
    end
    `CHK("echo rises", 10, rises)
  endtask
  task automatic t_legacy();
    int lat_n;
    int n;
    rd(AW'(0));
    drain();
    lat_n = last_lat;
    @(negedge i_clock);
    pll_n = 1'b0;
    n = 0;
    while (legacy !== 1'b1 && n < 200) begin
      @(negedge i_clock);
      n++;
    end
    `CHK("legacy mode", 1'b1, legacy)
    rd(AW'(0));
    drain();
    `CHK("latency gap", 12, lat_n - last_lat)
    wr(AW'(7), 36'h123456789, 4'h0);
    rd(AW'(7));
    rd(AW'(37));
    drain();
  endtask
  // ==========================================================
  // Main sequence and watchdog
  initial begin
    i_rst_n = 1'b0;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_addr = '0;
    req_data = 36'h0;
    req_be_n = 4'hF;
    pll_n = 1'b1;
    repeat (4) @(posedge i_clock);
    @(negedge i_clock);
    i_rst_n = 1'b1;
    t_basic();
    t_lanes();
    t_fifo();
    t_idle();
    t_legacy();
    results();
  end
  // Whole run needs under two thousand cycles; allow fifteen times that
  initial begin
    #(50 * 30000);
    fail_count++;
    $display("BAD watchdog exp done got hang");
    results();
  end
endmodule
`default_nettype wire
